//--- hdl/drive_status_cfg.svh
// constants and register map of the drive status output selector
// Functional notes
// - code 0: on when |preset - output freq| <= bandwidth/2
// - hold level and bandwidth; refuse values above max frequency
// - code 1: preset equals level and code 0 condition true
// - code 2: on when |level - run freq| <= bandwidth/2
// - code 3: on at level rising, held while above level - bandwidth/2
// - code 4: inverse of the code 3 hysteresis result
// - codes 5,6,7: motor overload warning, inverter overload, stall
// - code 8: over-voltage, above 400 V or 820 V by class
// - code 9: low voltage, below 180 V or 360 V by class
// - code 10 heatsink overheat; code 11 speed command loss
// - code 12: run command present and output voltage active
// - code 13 stopped without command; code 14 constant speed
// - code 16: normal operation waiting for a run command
// - code 17: output follows fault relay configuration bits
// - config bit 0 low-voltage trip, bit 1 other trip, bit 2 restart
// - code 18: fan alarm while fan trip response is 0
// - code 19: brake control signal
// - lasting keypad error drives open collector (bit 0), relay (bit 1)
// - thermal trip, inverse time; one-minute level not below continuous
// - motor type 0 cools less at low speed; type 1 has own fan
// - overload warning after current above level for warning time
// - overload trip after current above trip level for trip time
`ifndef DRIVE_STATUS_CFG_SVH
`define DRIVE_STATUS_CFG_SVH
`define CLK_PERIOD_NS 100
`define TICK_PERIOD_NS 1000000
`define TICKS_PER_SEC 17'h003e8
`define KP_ERR_TICKS 17'h003e8
`define TH_WINDOW_SEC 32'h0000003c
`define A_LEVEL 8'h00
`define A_BW 8'h04
`define A_MAXF 8'h08
`define A_OCSEL 8'h0c
`define A_RLSEL 8'h10
`define A_FCFG 8'h14
`define A_KPSEL 8'h18
`define A_THERM 8'h1c
`define A_WARN 8'h20
`define A_TRIP 8'h24
`define A_FAN 8'h28
`define A_STAT 8'h2c
`define F_FREQ 15:0
`define F_SEL 4:0
`define F_FCFG 2:0
`define F_KP 1:0
`define B_EN 0
`define B_TYPE 1
`define F_HI 15:8
`define F_LO 7:0
`define F_CONT 23:16
`define F_TIME 20:16
`define F_TTIME 21:16
`define B_OC 0
`define B_RL 1
`define B_WARN 2
`define B_OVL 3
`define B_TH 4
`define B_FDT4 5
`define B_KP 6
`define R_LEVEL 16'h0bb8
`define R_BW 16'h03e8
`define R_MAXF 16'h1770
`define R_OCSEL 5'h0c
`define R_RLSEL 5'h11
`define R_FCFG 3'h2
`define R_TH1M 8'h96
`define R_THC 8'h64
`define R_WLVL 8'h96
`define R_WTIME 5'h0a
`define R_TLVL 8'hb4
`define R_TTIME 6'h3c
`define FREQ_LIM 16'h9c40
`define SEL_LIM 5'h13
`define TH1M_MIN 8'h32
`define TH1M_MAX 8'hc8
`define THC_MAX 8'h96
`define WLVL_MIN 8'h1e
`define WLVL_MAX 8'h96
`define WTIME_MAX 5'h1e
`define TLVL_MAX 8'hc8
`define TTIME_MAX 6'h3c
`define OV_200 10'h190
`define OV_400 10'h334
`define LV_200 10'h0b4
`define LV_400 10'h168
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`endif

//--- hdl/drive_status_pkg.sv
// state type of the drive status output selector
package drive_status_pkg;
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] bw;
    logic [15:0] maxf;
    logic [4:0] oc_sel;
    logic [4:0] rl_sel;
    logic [2:0] fcfg;
    logic [1:0] kp_sel;
    logic th_en;
    logic mtype;
    logic [7:0] th1m;
    logic [7:0] thc;
    logic [7:0] wlvl;
    logic [4:0] wtime;
    logic trip_en;
    logic [7:0] tlvl;
    logic [5:0] ttime;
    logic fan_resp;
    logic [23:0] div;
    logic tick;
    logic [16:0] wcnt;
    logic [16:0] tcnt;
    logic [16:0] kcnt;
    logic [31:0] th_acc;
    logic fdt4;
    logic warn;
    logic ovl_trip;
    logic th_trip;
    logic kp_err;
    logic oc;
    logic relay;
    logic drive_off;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;
endpackage : drive_status_pkg

//--- hdl/drive_status_output_selector.sv
// status selector driving the open-collector output and the relay
`timescale 1ns/1ps
`include "drive_status_cfg.svh"
module drive_status_output_selector #(
  parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic [15:0] preset_freq_i,
  input wire logic [15:0] run_freq_i,
  input wire logic [7:0] motor_current_i,
  input wire logic [9:0] dc_link_v_i,
  input wire logic class_400v_i,
  input wire logic inverter_overload_flag_i,
  input wire logic stall_i,
  input wire logic heatsink_overheat_i,
  input wire logic cmd_loss_i,
  input wire logic run_cmd_i,
  input wire logic output_active_i,
  input wire logic constant_speed_i,
  input wire logic other_trip_i,
  input wire logic auto_restart_i,
  input wire logic fan_fault_i,
  input wire logic brake_i,
  input wire logic keypad_err_i,
  output logic open_collector_output_o,
  output logic relay_output_o,
  output logic drive_off_o
);
  drive_status_pkg::state_t st_ff;
  drive_status_pkg::state_t nxt_st;
  logic [15:0] half_bw;
  logic [15:0] d_pre;
  logic [15:0] d_lvl;
  logic fdt1;
  logic fdt3;
  logic fdt4_n;
  logic ov;
  logic lv;
  logic fault_out;
  logic [7:0] eff_cont;
  logic [19:0] cond;

  assign half_bw = st_ff.bw >> 1;
  assign d_pre = (preset_freq_i > run_freq_i) ?
    preset_freq_i - run_freq_i : run_freq_i - preset_freq_i;
  assign d_lvl = (st_ff.level > run_freq_i) ?
    st_ff.level - run_freq_i : run_freq_i - st_ff.level;
  assign fdt1 = d_pre <= half_bw;
  assign fdt3 = d_lvl <= half_bw;
  // rising side sets at the level, falling side releases below the band
  assign fdt4_n = (run_freq_i >= st_ff.level) ? 1'b1 :
    (({1'b0, run_freq_i} + {1'b0, half_bw}) > {1'b0, st_ff.level}) ?
    st_ff.fdt4 : 1'b0;
  assign ov = class_400v_i ? dc_link_v_i > `OV_400 :
    dc_link_v_i > `OV_200;
  assign lv = class_400v_i ? dc_link_v_i < `LV_400 :
    dc_link_v_i < `LV_200;
  assign fault_out = (st_ff.fcfg[0] && lv) ||
    (st_ff.fcfg[1] && (other_trip_i || ov || st_ff.drive_off)) ||
    (st_ff.fcfg[2] && auto_restart_i);
  // shaft-cooled motor tolerates less current below half max frequency
  assign eff_cont = (!st_ff.mtype && run_freq_i < (st_ff.maxf >> 1)) ?
    st_ff.thc - (st_ff.thc >> 2) : st_ff.thc;

  always_comb begin
    cond = '0;
    cond[0] = fdt1;
    cond[1] = (preset_freq_i == st_ff.level) && fdt1;
    cond[2] = fdt3;
    cond[3] = fdt4_n;
    cond[4] = !fdt4_n;
    cond[5] = st_ff.warn;
    cond[6] = inverter_overload_flag_i;
    cond[7] = stall_i;
    cond[8] = ov;
    cond[9] = lv;
    cond[10] = heatsink_overheat_i;
    cond[11] = cmd_loss_i;
    cond[12] = run_cmd_i && output_active_i;
    cond[13] = !run_cmd_i && !output_active_i;
    cond[14] = constant_speed_i && output_active_i;
    cond[16] = !run_cmd_i && !other_trip_i && !st_ff.drive_off;
    cond[17] = fault_out;
    cond[18] = fan_fault_i && !st_ff.fan_resp;
    cond[19] = brake_i;
  end

  function automatic logic [31:0] rd_word(
    input drive_status_pkg::state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      `A_LEVEL: r[`F_FREQ] = s.level;
      `A_BW: r[`F_FREQ] = s.bw;
      `A_MAXF: r[`F_FREQ] = s.maxf;
      `A_OCSEL: r[`F_SEL] = s.oc_sel;
      `A_RLSEL: r[`F_SEL] = s.rl_sel;
      `A_FCFG: r[`F_FCFG] = s.fcfg;
      `A_KPSEL: r[`F_KP] = s.kp_sel;
      `A_THERM: begin
        r[`B_EN] = s.th_en;
        r[`B_TYPE] = s.mtype;
        r[`F_HI] = s.th1m;
        r[`F_CONT] = s.thc;
      end
      `A_WARN: begin
        r[`F_LO] = s.wlvl;
        r[`F_TIME] = s.wtime;
      end
      `A_TRIP: begin
        r[`F_LO] = s.tlvl;
        r[`F_TTIME] = s.ttime;
        r[`B_EN] = s.trip_en;
      end
      `A_FAN: r[`B_EN] = s.fan_resp;
      `A_STAT: begin
        r[`B_OC] = s.oc;
        r[`B_RL] = s.relay;
        r[`B_WARN] = s.warn;
        r[`B_OVL] = s.ovl_trip;
        r[`B_TH] = s.th_trip;
        r[`B_FDT4] = s.fdt4;
        r[`B_KP] = s.kp_err;
      end
      default: r = '0;
    endcase
    return r;
  endfunction : rd_word

  function automatic logic hit(input logic [7:0] a);
    return a <= `A_STAT && a[1:0] == 2'h0;
  endfunction : hit

  always_comb begin
    logic [31:0] m;
    logic [31:0] v;
    logic bad;
    logic [16:0] wl;
    logic [16:0] tl;
    logic [31:0] hl;
    m = '0;
    v = '0;
    bad = 1'b0;
    wl = '0;
    tl = '0;
    hl = '0;
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.div == 24'(TICK_CYCLES - 1)) begin
      nxt_st.div = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 24'h000001;
    end
    if (arvalid_i && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_word(st_ff, araddr_i);
      nxt_st.rresp = hit(araddr_i) ? `RESP_OKAY : `RESP_DECERR;
    end else if (st_ff.rvalid && rready_i) begin
      nxt_st.rvalid = 1'b0;
    end
    nxt_st.arready = !nxt_st.rvalid;
    if (awvalid_i && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = awaddr_i;
    end
    if (wvalid_i && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = wdata_i;
      nxt_st.wstrb = wstrb_i;
    end
    if (st_ff.bvalid && bready_i) begin
      nxt_st.bvalid = 1'b0;
    end
    if (nxt_st.aw_got && nxt_st.w_got && !st_ff.bvalid) begin
      for (int i = 0; i < 4; i++) begin
        m[i*8 +: 8] = {8{nxt_st.wstrb[i]}};
      end
      v = (rd_word(st_ff, nxt_st.awaddr) & ~m) | (nxt_st.wdata & m);
      case (nxt_st.awaddr)
        `A_LEVEL: begin
          bad = v[`F_FREQ] > st_ff.maxf;
          if (!bad) nxt_st.level = v[`F_FREQ];
        end
        `A_BW: begin
          bad = v[`F_FREQ] > st_ff.maxf;
          if (!bad) nxt_st.bw = v[`F_FREQ];
        end
        `A_MAXF: begin
          bad = v[`F_FREQ] > `FREQ_LIM;
          if (!bad) nxt_st.maxf = v[`F_FREQ];
        end
        `A_OCSEL: begin
          bad = v[`F_SEL] > `SEL_LIM;
          if (!bad) nxt_st.oc_sel = v[`F_SEL];
        end
        `A_RLSEL: begin
          bad = v[`F_SEL] > `SEL_LIM;
          if (!bad) nxt_st.rl_sel = v[`F_SEL];
        end
        `A_FCFG: nxt_st.fcfg = v[`F_FCFG];
        `A_KPSEL: nxt_st.kp_sel = v[`F_KP];
        `A_THERM: begin
          bad = v[`F_HI] < v[`F_CONT] || v[`F_HI] > `TH1M_MAX ||
            v[`F_CONT] < `TH1M_MIN || v[`F_CONT] > `THC_MAX;
          if (!bad) begin
            nxt_st.th_en = v[`B_EN];
            nxt_st.mtype = v[`B_TYPE];
            nxt_st.th1m = v[`F_HI];
            nxt_st.thc = v[`F_CONT];
          end
        end
        `A_WARN: begin
          bad = v[`F_LO] < `WLVL_MIN || v[`F_LO] > `WLVL_MAX ||
            v[`F_TIME] > `WTIME_MAX;
          if (!bad) begin
            nxt_st.wlvl = v[`F_LO];
            nxt_st.wtime = v[`F_TIME];
          end
        end
        `A_TRIP: begin
          bad = v[`F_LO] < `WLVL_MIN || v[`F_LO] > `TLVL_MAX ||
            v[`F_TTIME] > `TTIME_MAX;
          if (!bad) begin
            nxt_st.tlvl = v[`F_LO];
            nxt_st.ttime = v[`F_TTIME];
            nxt_st.trip_en = v[`B_EN];
          end
        end
        `A_FAN: nxt_st.fan_resp = v[`B_EN];
        `A_STAT: begin
          // trip flags are write-one-to-clear; a new trip below wins
          if (nxt_st.wdata[`B_OVL] && nxt_st.wstrb[0]) begin
            nxt_st.ovl_trip = 1'b0;
          end
          if (nxt_st.wdata[`B_TH] && nxt_st.wstrb[0]) begin
            nxt_st.th_trip = 1'b0;
          end
        end
        default: bad = 1'b0;
      endcase
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = !hit(nxt_st.awaddr) ? `RESP_DECERR :
        bad ? `RESP_SLVERR : `RESP_OKAY;
    end
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;
    if (st_ff.tick) begin
      wl = 17'(st_ff.wtime * `TICKS_PER_SEC);
      tl = 17'(st_ff.ttime * `TICKS_PER_SEC);
      hl = 32'((st_ff.th1m - st_ff.thc) * `TH_WINDOW_SEC *
        `TICKS_PER_SEC);
      if (motor_current_i > st_ff.wlvl) begin
        if (st_ff.wcnt < wl) nxt_st.wcnt = st_ff.wcnt + 17'h00001;
        nxt_st.warn = st_ff.wcnt >= wl;
      end else begin
        nxt_st.wcnt = '0;
        nxt_st.warn = 1'b0;
      end
      if (st_ff.trip_en && motor_current_i > st_ff.tlvl) begin
        if (st_ff.tcnt < tl) nxt_st.tcnt = st_ff.tcnt + 17'h00001;
        if (st_ff.tcnt >= tl) nxt_st.ovl_trip = 1'b1;
      end else begin
        nxt_st.tcnt = '0;
      end
      // excess current integrates; the model cools one unit per tick
      if (st_ff.th_en && motor_current_i > eff_cont) begin
        nxt_st.th_acc = st_ff.th_acc +
          32'(motor_current_i - eff_cont);
        if (st_ff.th_acc >= hl) nxt_st.th_trip = 1'b1;
      end else if (st_ff.th_acc != '0) begin
        nxt_st.th_acc = st_ff.th_acc - 32'h00000001;
      end
      if (keypad_err_i) begin
        if (st_ff.kcnt < `KP_ERR_TICKS) begin
          nxt_st.kcnt = st_ff.kcnt + 17'h00001;
        end
        nxt_st.kp_err = st_ff.kcnt >= `KP_ERR_TICKS;
      end else begin
        nxt_st.kcnt = '0;
        nxt_st.kp_err = 1'b0;
      end
      nxt_st.fdt4 = fdt4_n;
      nxt_st.oc = cond[st_ff.oc_sel] ||
        (st_ff.kp_err && st_ff.kp_sel[0]);
      nxt_st.relay = cond[st_ff.rl_sel] ||
        (st_ff.kp_err && st_ff.kp_sel[1]);
      nxt_st.drive_off = st_ff.ovl_trip || st_ff.th_trip;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.level <= `R_LEVEL;
      st_ff.bw <= `R_BW;
      st_ff.maxf <= `R_MAXF;
      st_ff.oc_sel <= `R_OCSEL;
      st_ff.rl_sel <= `R_RLSEL;
      st_ff.fcfg <= `R_FCFG;
      st_ff.th1m <= `R_TH1M;
      st_ff.thc <= `R_THC;
      st_ff.wlvl <= `R_WLVL;
      st_ff.wtime <= `R_WTIME;
      st_ff.trip_en <= 1'b1;
      st_ff.tlvl <= `R_TLVL;
      st_ff.ttime <= `R_TTIME;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign awready_o = st_ff.awready;
  assign wready_o = st_ff.wready;
  assign bvalid_o = st_ff.bvalid;
  assign bresp_o = st_ff.bresp;
  assign arready_o = st_ff.arready;
  assign rvalid_o = st_ff.rvalid;
  assign rdata_o = st_ff.rdata;
  assign rresp_o = st_ff.rresp;
  assign open_collector_output_o = st_ff.oc;
  assign relay_output_o = st_ff.relay;
  assign drive_off_o = st_ff.drive_off;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_fdt1;
    st_ff.tick && st_ff.oc_sel == 5'h00 && !st_ff.kp_err
      |=> open_collector_output_o == $past(fdt1);
  endproperty
  a_fdt1: assert property (p_fdt1)
    else $error("code 0 output mismatch");
  property p_fdt2;
    st_ff.tick && st_ff.oc_sel == 5'h01 && !st_ff.kp_err
      |=> open_collector_output_o ==
        $past(preset_freq_i == st_ff.level && fdt1);
  endproperty
  a_fdt2: assert property (p_fdt2)
    else $error("code 1 output mismatch");
  property p_fdt5;
    st_ff.tick && st_ff.rl_sel == 5'h04 && !st_ff.kp_err
      |=> relay_output_o == !st_ff.fdt4;
  endproperty
  a_fdt5: assert property (p_fdt5)
    else $error("code 4 relay not inverse of hysteresis");
  property p_ov;
    st_ff.tick && st_ff.oc_sel == 5'h08 && !st_ff.kp_err
      |=> open_collector_output_o == $past(ov);
  endproperty
  a_ov: assert property (p_ov)
    else $error("over-voltage output mismatch");
  property p_tick_only;
    !st_ff.tick |=> $stable(open_collector_output_o) &&
      $stable(relay_output_o);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("output changed outside a tick");
  // the write is applied on the taking edge, so check at the response
  property p_lvl_reject;
    $rose(bvalid_o) && st_ff.awaddr == `A_LEVEL && st_ff.wstrb == 4'hf &&
      st_ff.wdata[`F_FREQ] > st_ff.maxf
      |-> $stable(st_ff.level) && bresp_o == `RESP_SLVERR;
  endproperty
  a_lvl_reject: assert property (p_lvl_reject)
    else $error("level above max frequency accepted");
  property p_warn;
    $rose(st_ff.warn) |->
      $past(st_ff.wcnt) >= 17'($past(st_ff.wtime) * `TICKS_PER_SEC);
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning raised before its time");
  property p_th_order;
    st_ff.thc <= st_ff.th1m;
  endproperty
  a_th_order: assert property (p_th_order)
    else $error("one-minute level below continuous");
  property p_off;
    $rose(drive_off_o) |-> $past(st_ff.ovl_trip || st_ff.th_trip);
  endproperty
  a_off: assert property (p_off)
    else $error("drive off without a trip");
endmodule : drive_status_output_selector

//--- verification/drive_sequence_reader.sv
// outside control sequence model that reads the two output terminals
`timescale 1ns/1ps
module drive_sequence_reader (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic open_collector_output_i,
  input wire logic relay_output_i,
  output logic oc_seen_o,
  output logic relay_seen_o
);
  // terminals are read one clock late, as a sequence behind them would
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oc_seen_o <= 1'b0;
      relay_seen_o <= 1'b0;
    end else begin
      oc_seen_o <= open_collector_output_i;
      relay_seen_o <= relay_output_i;
    end
  end
endmodule : drive_sequence_reader

//--- verification/drive_status_output_selector_tb.sv
// register and terminal tests of the drive status output selector
`timescale 1ns/1ps
`include "drive_status_cfg.svh"
module drive_status_output_selector_tb;
  localparam int TICK = 10;
  logic clock_i = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [15:0] preset_f = 16'h0;
  logic [15:0] run_f = 16'h0;
  logic [7:0] cur = 8'h32;
  logic [9:0] dc_v = 10'h12c;
  logic cls4 = 1'b0;
  // flag map: inv stall heat loss run act const other rst fan brake kp
  logic [11:0] fl = 12'h0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0] bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic oc_o, relay_o, drive_off_o, oc_seen, relay_seen;
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
    8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
  logic [31:0] rv [12] = '{32'h0bb8, 32'h03e8, 32'h1770, 32'h0c, 32'h11,
    32'h2, 32'h0, 32'h00649600, 32'h000a0096, 32'h003c00b5, 32'h0,
    32'h0};

  always #50 clock_i = ~clock_i;

  drive_status_output_selector #(.TICK_CYCLES(TICK)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready_o),
    .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid),
    .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
    .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .rvalid_o(rvalid_o), .rready_i(rready),
    .preset_freq_i(preset_f), .run_freq_i(run_f),
    .motor_current_i(cur), .dc_link_v_i(dc_v), .class_400v_i(cls4),
    .inverter_overload_flag_i(fl[11]), .stall_i(fl[10]),
    .heatsink_overheat_i(fl[9]), .cmd_loss_i(fl[8]),
    .run_cmd_i(fl[7]), .output_active_i(fl[6]),
    .constant_speed_i(fl[5]), .other_trip_i(fl[4]),
    .auto_restart_i(fl[3]), .fan_fault_i(fl[2]), .brake_i(fl[1]),
    .keypad_err_i(fl[0]), .open_collector_output_o(oc_o),
    .relay_output_o(relay_o), .drive_off_o(drive_off_o)
  );

  drive_sequence_reader u_seq (
    .clock_i(clock_i), .rst_n_i(rst_n),
    .open_collector_output_i(oc_o), .relay_output_i(relay_o),
    .oc_seen_o(oc_seen), .relay_seen_o(relay_seen)
  );

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wait_ticks(input int n);
    repeat (n * TICK) @(posedge clock_i);
  endtask : wait_ticks

  // address and data are offered together; each drops once it is taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw_done, w_done;
    int n;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done) && n < 200) begin
      @(posedge clock_i);
      n++;
      if (awvalid === 1'b1 && awready_o === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready_o === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (bvalid_o !== 1'b1 && n < 200);
    bready <= 1'b0;
    if (n >= 200) fail_count++;
    cmp({30'h0, bresp_o}, {30'h0, er});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (arready_o !== 1'b1 && n < 200);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (rvalid_o !== 1'b1 && n < 200);
    rready <= 1'b0;
    if (n >= 200) fail_count++;
    cmp({30'h0, rresp_o}, {30'h0, er});
    if (er === `RESP_OKAY) cmp(rdata_o, ed);
  endtask : axi_read

  // select a code, set the inputs, let three ticks pass, read the terminal
  task automatic chk(input logic [4:0] code, input logic [11:0] f,
    input logic [9:0] dc, input logic c4, input logic [15:0] pf,
    input logic [15:0] rf, input logic e);
    axi_write(`A_OCSEL, {27'h0, code}, `RESP_OKAY);
    fl <= f;
    dc_v <= dc;
    cls4 <= c4;
    preset_f <= pf;
    run_f <= rf;
    wait_ticks(3);
    cmp({31'h0, oc_seen}, {31'h0, e});
  endtask : chk

  initial begin
    #6000000;
    fail_count++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock_i);
    for (int i = 0; i < 12; i++) axi_read(ra[i], rv[i], `RESP_OKAY);
    axi_read(8'h30, 32'h0, `RESP_DECERR);
    axi_write(8'h01, 32'h0, `RESP_DECERR);
    axi_write(`A_BW, 32'h1771, `RESP_SLVERR);
    axi_write(`A_LEVEL, 32'h1771, `RESP_SLVERR);
    axi_read(`A_BW, 32'h03e8, `RESP_OKAY);
    axi_write(`A_OCSEL, 32'h14, `RESP_SLVERR);
    // 30.00 Hz level, 10.00 Hz band: edges at 25.00 and 35.00 Hz
    chk(5'h00, 12'h0, 10'h12c, 1'b0, 16'h0bb8, 16'h0dac, 1'b1);
    chk(5'h00, 12'h0, 10'h12c, 1'b0, 16'h0bb8, 16'h0dad, 1'b0);
    chk(5'h01, 12'h0, 10'h12c, 1'b0, 16'h0bb8, 16'h0bb8, 1'b1);
    chk(5'h01, 12'h0, 10'h12c, 1'b0, 16'h0c1c, 16'h0c1c, 1'b0);
    chk(5'h02, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h09c4, 1'b1);
    chk(5'h02, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h09c3, 1'b0);
    chk(5'h03, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h0bb7, 1'b0);
    chk(5'h03, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h0bb8, 1'b1);
    chk(5'h03, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h09c5, 1'b1);
    chk(5'h04, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h09c5, 1'b0);
    chk(5'h04, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h09c4, 1'b1);
    axi_write(`A_RLSEL, 32'h04, `RESP_OKAY);
    wait_ticks(3);
    cmp({31'h0, relay_seen}, 32'h1);
    axi_write(`A_RLSEL, 32'h11, `RESP_OKAY);
    chk(5'h03, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h09c4, 1'b0);
    chk(5'h06, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b0);
    chk(5'h06, 12'h800, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h07, 12'h400, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h08, 12'h0, 10'h191, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h08, 12'h0, 10'h190, 1'b0, 16'h0, 16'h0, 1'b0);
    chk(5'h08, 12'h0, 10'h335, 1'b1, 16'h0, 16'h0, 1'b1);
    chk(5'h08, 12'h0, 10'h334, 1'b1, 16'h0, 16'h0, 1'b0);
    chk(5'h09, 12'h0, 10'h0b3, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h09, 12'h0, 10'h0b4, 1'b0, 16'h0, 16'h0, 1'b0);
    chk(5'h09, 12'h0, 10'h167, 1'b1, 16'h0, 16'h0, 1'b1);
    chk(5'h09, 12'h0, 10'h168, 1'b1, 16'h0, 16'h0, 1'b0);
    chk(5'h0a, 12'h200, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h0b, 12'h100, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h0c, 12'h080, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b0);
    chk(5'h0c, 12'h0c0, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h0d, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h0d, 12'h080, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b0);
    chk(5'h0e, 12'h060, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h10, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h10, 12'h080, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b0);
    chk(5'h11, 12'h010, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h11, 12'h0, 10'h0aa, 1'b0, 16'h0, 16'h0, 1'b0);
    axi_write(`A_FCFG, 32'h1, `RESP_OKAY);
    chk(5'h11, 12'h0, 10'h0aa, 1'b0, 16'h0, 16'h0, 1'b1);
    axi_write(`A_FCFG, 32'h4, `RESP_OKAY);
    chk(5'h11, 12'h008, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h12, 12'h004, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    axi_write(`A_FAN, 32'h1, `RESP_OKAY);
    chk(5'h12, 12'h004, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b0);
    chk(5'h13, 12'h002, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(5'h13, 12'h0, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b0);
    // keypad error must last 1000 ticks before the relay reports it
    axi_write(`A_KPSEL, 32'h2, `RESP_OKAY);
    chk(5'h07, 12'h001, 10'h12c, 1'b0, 16'h0, 16'h0, 1'b0);
    wait_ticks(897);
    cmp({31'h0, relay_seen}, 32'h0);
    wait_ticks(200);
    cmp({31'h0, relay_seen}, 32'h1);
    cmp({31'h0, oc_seen}, 32'h0);
    axi_write(`A_KPSEL, 32'h0, `RESP_OKAY);
    fl <= 12'h0;
    // warning after one second above 150 percent
    axi_write(`A_WARN, 32'h00010096, `RESP_OKAY);
    axi_write(`A_OCSEL, 32'h05, `RESP_OKAY);
    cur <= 8'h97;
    wait_ticks(900);
    cmp({31'h0, oc_seen}, 32'h0);
    wait_ticks(250);
    cmp({31'h0, oc_seen}, 32'h1);
    cur <= 8'h32;
    // one-minute level below continuous is refused
    axi_write(`A_THERM, 32'h00966400, `RESP_SLVERR);
    // 101/100 percent with own fan: trips after 600 ticks at 200 percent
    axi_write(`A_THERM, 32'h00646503, `RESP_OKAY);
    cur <= 8'hc8;
    wait_ticks(500);
    cmp({31'h0, drive_off_o}, 32'h0);
    wait_ticks(200);
    cmp({31'h0, drive_off_o}, 32'h1);
    conclude();
  end
endmodule : drive_status_output_selector_tb
